// ---- panel_pkg.sv ----
// Shared constants and types for the pushbutton panel register logic.
// Assumes a controller-side holding register bank that is reached word by word.
package panel_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int unsigned NUM_BUTTONS = 24;
	localparam int unsigned REG_W       = 16;
	localparam int unsigned HIGH_W      = NUM_BUTTONS - REG_W;

	// ----------------------------------------
	// Bank word offsets from the first register
	// ----------------------------------------
	localparam logic [2:0] OFS_STATUS_LO  = 3'h0;
	localparam logic [2:0] OFS_STATUS_HI  = 3'h1;
	localparam logic [2:0] OFS_FLASH_LO   = 3'h2;
	localparam logic [2:0] OFS_FLASH_HI   = 3'h3;
	localparam logic [2:0] OFS_LAMP_LO    = 3'h4;
	localparam logic [2:0] OFS_LAMP_HI    = 3'h5;
	localparam logic [2:0] OFS_FORCE_LO   = 3'h6;
	localparam logic [2:0] OFS_FORCE_HI   = 3'h7;

	// ----------------------------------------
	// Command bits in the last word
	// ----------------------------------------
	localparam int unsigned FORCE_ALL_STATUS_CMD_BIT = 15;
	localparam int unsigned FORCE_ON_CMD_BIT         = 14;
	localparam int unsigned FORCE_CLEAR_CMD_BIT      = 13;
	localparam logic [REG_W-1:0] CMD_CLEAR_MASK      = 16'h1fff;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [NUM_BUTTONS-1:0] BUTTONS_RST = 24'h000000;
	localparam logic [2:0]             CMD_RST     = 3'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned FLASH_ON_MS   = 500;
	localparam int unsigned FLASH_OFF_MS  = 250;
	localparam logic [9:0]  FLASH_ON_CNT  = 10'(FLASH_ON_MS);
	localparam logic [9:0]  FLASH_END_CNT = 10'(FLASH_ON_MS + FLASH_OFF_MS - 1);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic             rd;
		logic             wr;
		logic [2:0]       addr;
		logic [REG_W-1:0] wdata;
	} bank_req_t;

	typedef enum logic [1:0] {
		ST_ACCESS,
		ST_APPLY,
		ST_WRITEBACK
	} poll_state_t;

endpackage

// ---- pushbutton_panel_register_logic.sv ----
// Button state, lamp drive and register bank polling for a 24-button panel.
// Assumes debounced synchronous buttons and a one-cycle bank ack per request.
`timescale 1ns/1ns
// Contract
// - Status bit is 1 when button active
// - Button n sits on bit n-1
// - Separation mode lights lamps from bank bits
// - Separation only for momentary buttons
// - Normal mode lamp follows button status
// - Flash only when lamp is on
// - Flash half second lit, quarter dark
// - Force status sets alternate buttons, self-clears
// - Force on sets selected buttons, self-clears
// - Clear turns selected buttons off, self-clears
// - Unselected buttons keep state under on/clear
// - Forces touch alternate-action buttons only
// - Contiguous bank, status words first
// - Last word: high force data, commands
// - Alternate toggles per press, momentary held
module pushbutton_panel_register_logic
	import panel_pkg::*;
#(parameter int unsigned MS_CYCLES = MS_CYC) (
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic [NUM_BUTTONS-1:0] button_pressed_in,
	input  wire logic [NUM_BUTTONS-1:0] alt_action_in,
	input  wire logic                   led_sep_mode_in,
	output bank_req_t                   bank_req_out,
	input  wire logic                   bank_ack_in,
	input  wire logic [REG_W-1:0]       bank_rdata_in,
	output logic      [NUM_BUTTONS-1:0] lamp_out,
	output logic      [NUM_BUTTONS-1:0] button_status_out
);
	localparam int unsigned MS_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	poll_state_t                state_q, state_d;
	logic [2:0]                 addr_q, addr_d;
	bank_req_t                  req_q, req_d;
	logic [NUM_BUTTONS-1:0]     flash_q, flash_d;
	logic [NUM_BUTTONS-1:0]     lamp_on_q, lamp_on_d;
	logic [NUM_BUTTONS-1:0]     force_q, force_d;
	logic [2:0]                 cmd_q, cmd_d;
	logic [REG_W-1:0]           last_word_q, last_word_d;
	logic [NUM_BUTTONS-1:0]     alt_q, alt_d;
	logic [NUM_BUTTONS-1:0]     prev_q, on_vec;
	logic [NUM_BUTTONS-1:0]     status_q, status_d;
	logic [NUM_BUTTONS-1:0]     lamp_q, lamp_d;
	logic [MS_W-1:0]            ms_cnt_q, ms_cnt_d;
	logic [9:0]                 flash_ms_q, flash_ms_d;
	logic                       ms_tick, lit, apply;
	// Apply cycle marker
	assign apply = (state_q == ST_APPLY);
	// ----------------------------------------
	// Polling sequence over the bank
	// ----------------------------------------
	// Next poll step, captured words and request
	always_comb begin
		state_d     = state_q;
		addr_d      = addr_q;
		flash_d     = flash_q;
		lamp_on_d   = lamp_on_q;
		force_d     = force_q;
		cmd_d       = cmd_q;
		last_word_d = last_word_q;
		case (state_q)
			ST_ACCESS: begin
				if (bank_ack_in) begin
					case (addr_q)
						OFS_FLASH_LO: flash_d[REG_W-1:0] = bank_rdata_in;
						OFS_FLASH_HI: flash_d[NUM_BUTTONS-1:REG_W] = bank_rdata_in[HIGH_W-1:0];
						OFS_LAMP_LO:  lamp_on_d[REG_W-1:0] = bank_rdata_in;
						OFS_LAMP_HI:  lamp_on_d[NUM_BUTTONS-1:REG_W] = bank_rdata_in[HIGH_W-1:0];
						OFS_FORCE_LO: force_d[REG_W-1:0] = bank_rdata_in;
						OFS_FORCE_HI: begin
							force_d[NUM_BUTTONS-1:REG_W] = bank_rdata_in[HIGH_W-1:0];
							cmd_d = {bank_rdata_in[FORCE_ALL_STATUS_CMD_BIT],
								bank_rdata_in[FORCE_ON_CMD_BIT],
								bank_rdata_in[FORCE_CLEAR_CMD_BIT]};
							last_word_d = bank_rdata_in;
						end
						default: ;
					endcase
					if (addr_q == OFS_FORCE_HI) begin
						state_d = ST_APPLY;
					end else begin
						addr_d = addr_q + 3'h1;
					end
				end
			end
			ST_APPLY: begin
				addr_d  = OFS_STATUS_LO;
				state_d = (cmd_q != CMD_RST) ? ST_WRITEBACK : ST_ACCESS;
			end
			ST_WRITEBACK: begin
				if (bank_ack_in) begin
					cmd_d   = CMD_RST;
					state_d = ST_ACCESS;
				end
			end
			default: state_d = ST_ACCESS;
		endcase
		// Request follows the next step
		req_d = '0;
		case (state_d)
			ST_ACCESS: begin
				req_d.addr = addr_d;
				if (addr_d == OFS_STATUS_LO) begin
					req_d.wr    = 1'b1;
					req_d.wdata = status_q[REG_W-1:0];
				end else if (addr_d == OFS_STATUS_HI) begin
					req_d.wr    = 1'b1;
					req_d.wdata = {{(REG_W-HIGH_W){1'b0}}, status_q[NUM_BUTTONS-1:REG_W]};
				end else begin
					req_d.rd = 1'b1;
				end
			end
			ST_WRITEBACK: begin
				req_d.wr    = 1'b1;
				req_d.addr  = OFS_FORCE_HI;
				req_d.wdata = last_word_d & CMD_CLEAR_MASK;
			end
			default: ;
		endcase
	end
	// Register poll state
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q     <= ST_ACCESS;
			addr_q      <= OFS_STATUS_LO;
			req_q       <= '0;
			flash_q     <= BUTTONS_RST;
			lamp_on_q   <= BUTTONS_RST;
			force_q     <= BUTTONS_RST;
			cmd_q       <= CMD_RST;
			last_word_q <= '0;
		end else begin
			state_q     <= state_d;
			addr_q      <= addr_d;
			req_q       <= req_d;
			flash_q     <= flash_d;
			lamp_on_q   <= lamp_on_d;
			force_q     <= force_d;
			cmd_q       <= cmd_d;
			last_word_q <= last_word_d;
		end
	end
	// Request straight from its register
	assign bank_req_out = req_q;
	// ----------------------------------------
	// Button state and lamps
	// ----------------------------------------
	for (genvar i = 0; i < NUM_BUTTONS; i++) begin : g_button
		// Toggle and force per button
		always_comb begin
			alt_d[i] = alt_q[i];
			if (button_pressed_in[i] && !prev_q[i]) begin
				alt_d[i] = ~alt_q[i];
			end
			if (apply) begin
				if (cmd_q[2]) begin
					alt_d[i] = force_q[i];
				end
				if (cmd_q[1] && force_q[i]) begin
					alt_d[i] = 1'b1;
				end
				if (cmd_q[0] && force_q[i]) begin
					alt_d[i] = 1'b0;
				end
			end
			if (!alt_action_in[i]) begin
				alt_d[i] = 1'b0;
			end
			status_d[i] = alt_action_in[i] ? alt_d[i] : button_pressed_in[i];
			on_vec[i] = (led_sep_mode_in && !alt_action_in[i]) ? lamp_on_q[i] : status_q[i];
			lamp_d[i] = on_vec[i] && (!flash_q[i] || lit);
		end
	end
	// Register button state
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			alt_q    <= BUTTONS_RST;
			prev_q   <= BUTTONS_RST;
			status_q <= BUTTONS_RST;
			lamp_q   <= BUTTONS_RST;
		end else begin
			alt_q    <= alt_d;
			prev_q   <= button_pressed_in;
			status_q <= status_d;
			lamp_q   <= lamp_d;
		end
	end
	// Outputs from their registers
	assign button_status_out = status_q;
	assign lamp_out          = lamp_q;
	// ----------------------------------------
	// Flash timebase
	// ----------------------------------------
	// Millisecond tick and flash phase
	always_comb begin
		ms_tick    = (ms_cnt_q == MS_W'(MS_CYCLES - 1));
		ms_cnt_d   = ms_tick ? '0 : ms_cnt_q + MS_W'(1);
		flash_ms_d = flash_ms_q;
		if (ms_tick) begin
			flash_ms_d = (flash_ms_q == FLASH_END_CNT) ? 10'h000 : flash_ms_q + 10'h001;
		end
		lit = (flash_ms_q < FLASH_ON_CNT);
	end
	// Register timebase
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ms_cnt_q   <= '0;
			flash_ms_q <= 10'h000;
		end else begin
			ms_cnt_q   <= ms_cnt_d;
			flash_ms_q <= flash_ms_d;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_apply_cmd;
		apply && (cmd_q != CMD_RST);
	endsequence
	sequence s_writeback_req;
		req_q.wr && (req_q.addr == OFS_FORCE_HI) && (req_q.wdata[15:13] == 3'h0);
	endsequence
	property p_momentary_status;
		1'b1 |=> ((button_status_out ^ $past(button_pressed_in)) & ~$past(alt_action_in)) == '0;
	endproperty
	a_momentary_status: assert property (p_momentary_status)
		else $error("momentary status differs from button");
	property p_status_word_lo;
		$rose(req_q.wr) && (req_q.addr == OFS_STATUS_LO) |-> req_q.wdata == $past(status_q[15:0]);
	endproperty
	a_status_word_lo: assert property (p_status_word_lo)
		else $error("status word low mismatch");
	property p_dark_when_off;
		1'b1 |=> (lamp_out & ~$past(on_vec)) == '0;
	endproperty
	a_dark_when_off: assert property (p_dark_when_off) else $error("lamp lit while off");
	property p_normal_follow;
		!led_sep_mode_in && (flash_q == '0) |=> lamp_out == $past(status_q);
	endproperty
	a_normal_follow: assert property (p_normal_follow)
		else $error("lamp does not follow status");
	property p_flash_dark_phase;
		ms_tick && (flash_ms_q == FLASH_END_CNT) |=> lit && (flash_ms_q == 10'h000);
	endproperty
	a_flash_dark_phase: assert property (p_flash_dark_phase)
		else $error("flash period wrong");
	property p_force_status;
		apply && cmd_q[2] && !cmd_q[1] && !cmd_q[0] |=>
			((alt_q ^ $past(force_q)) & $past(alt_action_in)) == '0;
	endproperty
	a_force_status: assert property (p_force_status)
		else $error("force status not applied");
	property p_force_on_keep;
		apply && (cmd_q == 3'h2) |=> ((alt_q & $past(force_q & alt_action_in)) ==
			$past(force_q & alt_action_in));
	endproperty
	a_force_on_keep: assert property (p_force_on_keep)
		else $error("force on missed a button");
	property p_clear_sel;
		apply && (cmd_q == 3'h1) |=> (alt_q & $past(force_q)) == '0;
	endproperty
	a_clear_sel: assert property (p_clear_sel) else $error("clear missed a button");
	property p_momentary_untouched;
		s_apply_cmd |=> (alt_q & ~$past(alt_action_in)) == '0;
	endproperty
	a_momentary_untouched: assert property (p_momentary_untouched)
		else $error("force reached momentary button");
	property p_writeback;
		s_apply_cmd |=> s_writeback_req;
	endproperty
	a_writeback: assert property (p_writeback)
		else $error("commands not cleared after force");
endmodule

// ---- panel_bank_model.sv ----
// Controller-side bank of eight holding words polled by the panel.
// Assumes the req/ack handshake of panel_pkg; ack latency is set by the bench.
`timescale 1ns/1ns
module panel_bank_model
	import panel_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire bank_req_t        bank_req_in,
	output logic                  bank_ack_out,
	output logic      [REG_W-1:0] bank_rdata_out
);
	logic [REG_W-1:0] mem [8];
	int               delay = 0;
	int               cnt;

	// Bank starts cleared
	initial foreach (mem[i]) mem[i] = 16'h0000;

	// Controller program loading a word
	task automatic poke(input logic [2:0] a, input logic [REG_W-1:0] v);
		mem[a] = v;
	endtask

	// Ack after delay; read data scrambled outside the ack cycle
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bank_ack_out <= 1'b0;
			cnt <= 0;
			bank_rdata_out <= 16'h0000;
		end else if (bank_ack_out) begin
			if (bank_req_in.wr) mem[bank_req_in.addr] <= bank_req_in.wdata;
			bank_ack_out <= 1'b0;
			cnt <= 0;
			bank_rdata_out <= ~bank_rdata_out;
		end else if (bank_req_in.rd || bank_req_in.wr) begin
			if (cnt >= delay) begin
				bank_ack_out <= 1'b1;
				if (bank_req_in.rd) bank_rdata_out <= mem[bank_req_in.addr];
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// ---- pushbutton_panel_register_logic_tb.sv ----
// Self-checking bench for the pushbutton panel register logic.
// Assumes panel_bank_model as the controller bank; millisecond tick shortened to 4 cycles.
`timescale 1ns/1ns
module pushbutton_panel_register_logic_tb;
	import panel_pkg::*;
	localparam int unsigned MSC = 4;
	logic                   clk_in;
	logic                   rst_b_in;
	logic                   led_sep_mode_in;
	logic                   bank_ack_in;
	logic [NUM_BUTTONS-1:0] button_pressed_in;
	logic [NUM_BUTTONS-1:0] alt_action_in;
	logic [NUM_BUTTONS-1:0] lamp_out;
	logic [NUM_BUTTONS-1:0] button_status_out;
	logic [REG_W-1:0]       bank_rdata_in;
	bank_req_t              bank_req_out;
	int                     n_errors = 0;
	int                     checks = 0;

	pushbutton_panel_register_logic #(.MS_CYCLES(MSC)) pushbutton_panel_register_logic_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .button_pressed_in(button_pressed_in),
		.alt_action_in(alt_action_in), .led_sep_mode_in(led_sep_mode_in),
		.bank_req_out(bank_req_out), .bank_ack_in(bank_ack_in),
		.bank_rdata_in(bank_rdata_in), .lamp_out(lamp_out),
		.button_status_out(button_status_out));

	panel_bank_model panel_bank_model_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .bank_req_in(bank_req_out),
		.bank_ack_out(bank_ack_in), .bank_rdata_out(bank_rdata_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Wait for n acked writes of status word 0
	task automatic polls(input int n);
		int t;
		t = 0;
		while (n > 0 && t < 5000) begin
			@(posedge clk_in);
			t++;
			if (bank_ack_in === 1'b1 && bank_req_out.wr === 1'b1 &&
				bank_req_out.addr === OFS_STATUS_LO) n--;
		end
		if (n > 0) n_errors++;
		#1;
	endtask

	task automatic press(input logic [23:0] m);
		button_pressed_in = m;
		step();
		button_pressed_in = 24'h000000;
		step();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_status();
		button_pressed_in = 24'h010040;
		polls(2);
		chk24(button_status_out, 24'h010040);
		chk16(panel_bank_model_i.mem[0], 16'h0040);
		chk16(panel_bank_model_i.mem[1], 16'h0001);
		chk24(lamp_out, 24'h010040);
		button_pressed_in = 24'h000000;
		polls(2);
		chk24(button_status_out, 24'h000000);
	endtask

	task automatic t_toggle();
		alt_action_in = 24'h000003;
		press(24'h000001);
		polls(1);
		chk24(button_status_out, 24'h000001);
		press(24'h000001);
		polls(1);
		chk24(button_status_out, 24'h000000);
		press(24'h000001);
	endtask

	task automatic t_sep();
		led_sep_mode_in = 1'b1;
		panel_bank_model_i.poke(OFS_LAMP_LO, 16'h1002);
		panel_bank_model_i.poke(OFS_LAMP_HI, 16'h0080);
		polls(2);
		chk24(lamp_out, 24'h801001);
		led_sep_mode_in = 1'b0;
		polls(2);
		chk24(lamp_out, 24'h000001);
		led_sep_mode_in = 1'b1;
	endtask

	task automatic t_flash();
		int lit_on;
		int lit_off;
		lit_on = 0;
		lit_off = 0;
		panel_bank_model_i.delay = 3;
		panel_bank_model_i.poke(OFS_FLASH_LO, 16'h1020);
		polls(2);
		repeat (3000) begin
			step();
			if (lamp_out[12] === 1'b1) lit_on++;
			if (lamp_out[5] !== 1'b0) lit_off++;
		end
		chk16(16'(lit_on), 16'(FLASH_ON_MS * MSC));
		chk16(16'(lit_off), 16'h0000);
		panel_bank_model_i.poke(OFS_FLASH_LO, 16'h0000);
		panel_bank_model_i.delay = 0;
	endtask

	// Load data and command just after a status write, so one round reads both words
	task automatic force_cmd(input int b, input logic [23:0] d, input logic [23:0] exp);
		int t;
		t = 0;
		polls(1);
		panel_bank_model_i.poke(OFS_FORCE_LO, d[15:0]);
		panel_bank_model_i.poke(OFS_FORCE_HI, (16'h0001 << b) | {8'h00, d[23:16]});
		while (panel_bank_model_i.mem[7][15:13] !== 3'h0 && t < 500) begin
			step();
			t++;
		end
		chk16(panel_bank_model_i.mem[7], {8'h00, d[23:16]});
		polls(1);
		chk24(button_status_out, exp);
	endtask

	task automatic t_forces();
		alt_action_in = 24'h00ffff;
		force_cmd(FORCE_ALL_STATUS_CMD_BIT, 24'h8000f1, 24'h0000f1);
		force_cmd(FORCE_ON_CMD_BIT, 24'h810300, 24'h0003f1);
		force_cmd(FORCE_CLEAR_CMD_BIT, 24'h000110, 24'h0002e1);
	endtask

	task automatic conclude();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	initial begin
		#400000;
		n_errors++;
		conclude();
	end

	initial begin
		rst_b_in = 1'b0;
		led_sep_mode_in = 1'b0;
		button_pressed_in = 24'h000000;
		alt_action_in = 24'h000000;
		step(5);
		rst_b_in = 1'b1;
		t_status();
		t_toggle();
		t_sep();
		t_flash();
		t_forces();
		conclude();
	end
endmodule
